//--- src/rcs_regs.vh
`ifndef RCS_REGS_VH
`define RCS_REGS_VH

`define RCS_ADDR_OVERRIDE   8'h09
`define RCS_ADDR_OUTCTL     8'h12
`define RCS_ADDR_RATESEL    8'h1c
`define RCS_ADDR_RATEOV     8'h1d
`define RCS_ADDR_OUTSEL     8'h1e
`define RCS_ADDR_REFSTAT    8'h41

`define RCS_BIT_OVERRIDE    5
`define RCS_BIT_BYPASS      2
`define RCS_BIT_MUTE        1
`define RCS_BIT_CLKOUT      0
`define RCS_BIT_RATEOV      0
`define RCS_BIT_REFPRES     3
`define RCS_PRI_SEL_HI      6
`define RCS_PRI_SEL_LO      5
`define RCS_SEC_SEL_HI      4
`define RCS_SEC_SEL_LO      3

`define RCS_RST_OVERRIDE    8'h00
`define RCS_RST_OUTCTL      8'h02
`define RCS_RST_RATESEL     8'h00
`define RCS_RST_RATEOV      8'h00
`define RCS_RST_OUTSEL      8'h00

`define RCS_SRC_MUTE        2'h0
`define RCS_SRC_BYPASS      2'h1
`define RCS_SRC_RECLOCK     2'h2
`define RCS_SRC_CLOCK       2'h3

`define RCS_REF_HZ          27000000
`define RCS_CLK_HZ          100000000
`define RCS_REF_WIN_CYC     1024
`define RCS_REF_MIN_EDGES   8'h80
`define RCS_REF_MAX_EDGES   8'hff

`define RCS_FIFO_WIDTH      8
`define RCS_FIFO_DEPTH      16

`endif

//--- src/rcs_fifo.v
`timescale 1ns/10ps
module rcs_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             reset,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr_r;
    reg [AW:0]      rd_ptr_r;
    wire            full;
    wire            empty;
    wire            push;
    wire            pop;

    assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                       (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign empty     = (wr_ptr_r == rd_ptr_r);
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = mem[rd_ptr_r[AW-1:0]];
    assign push      = in_valid && ~full;
    assign pop       = out_ready && ~empty;

    always @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wr_ptr_r <= {(AW+1){1'b0}};
            rd_ptr_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule

//--- src/rcs_output_select.v
`timescale 1ns/10ps
`include "rcs_regs.vh"
// Functional notes
// - bypass: both outputs bypassed, clock-secondary muted
// - unsupported rate forces automatic bypass
// - lock indication low while bypassed
// - pin mode bypass follows high-active pin
// - spi mode bypass from 0x12 bit 2
// - eye monitor disabled during bypass
// - clock select puts recovered clock on secondary
// - clock secondary muted on bypass or unlock
// - pin mode clock select follows pin
// - spi clock select 0x12 bit 0
// - mute/bypass/clock/lock output table
// - override bit selects manual 0x1e fields
// - override ignores mute/clock, keeps bypass
// - primary manual select decode
// - secondary manual select decode
// - rate pins restrict lockable rates
// - rate pins default low means auto
// - 0x1d bit0 takes rate from 0x1c
// - spi entry keeps rate pins active
// - spi entry uses 0x12 bits 2:0
// - detect reference, report in 0x41 bit3
// - fractional rates distinguished only with reference
// - muted output drives constant zero
// - spi mute from 0x12 bit 1
// - mode pin 0 pin mode, 1 spi
module rcs_output_select (
    input  wire       clk,
    input  wire       reset,
    input  wire       spi_mode,
    input  wire       bypass_pin,
    input  wire       mute_n_pin,
    input  wire       clock_out_select_pin,
    input  wire       rate_pin_low,
    input  wire       rate_pin_high,
    input  wire       reference_input,
    input  wire       pll_locked,
    input  wire       rate_supported,
    input  wire       rate_fractional,
    input  wire [2:0] rate_detected,
    input  wire       reclocked_data,
    input  wire       bypassed_data,
    input  wire       recovered_clock,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    output reg        reg_rvalid,
    output reg        primary_serial_out,
    output reg        secondary_serial_out,
    output reg        lock_detect,
    output reg  [1:0] rate_restrict,
    output reg  [2:0] rate_status,
    output reg        reference_present_flag,
    output reg        eye_monitor_enable,
    output reg  [7:0] bypass_stream_data,
    output reg        bypass_stream_valid,
    input  wire [7:0] sample_data,
    input  wire       sample_valid,
    output reg        sample_ready,
    input  wire       bypass_stream_ready
);
    ////////////////////////////////////////////////////////////////////
    // registers
    reg [7:0] manual_output_override_r;
    reg [7:0] output_control_r;
    reg [7:0] rate_restriction_select_r;
    reg [7:0] rate_pin_override_r;
    reg [7:0] manual_output_select_r;

    wire       ovr_on   = manual_output_override_r[`RCS_BIT_OVERRIDE];
    wire [1:0] pri_sel  = manual_output_select_r[`RCS_PRI_SEL_HI:
                                                 `RCS_PRI_SEL_LO];
    wire [1:0] sec_sel  = manual_output_select_r[`RCS_SEC_SEL_HI:
                                                 `RCS_SEC_SEL_LO];

    // source decode shared by both outputs
    function [1:0] data_src;
        input locked;
        begin
            data_src = locked ? `RCS_SRC_RECLOCK : `RCS_SRC_BYPASS;
        end
    endfunction

    function drive_src;
        input [1:0] src;
        input       rc;
        input       bp;
        input       ck;
        begin
            case (src)
                `RCS_SRC_RECLOCK: drive_src = rc;
                `RCS_SRC_BYPASS:  drive_src = bp;
                `RCS_SRC_CLOCK:   drive_src = ck;
                default:          drive_src = 1'b0;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // effective controls
    reg       eff_bypass;
    reg       eff_mute_n;
    reg       eff_clkout;
    reg       eff_lock;
    reg [1:0] pri_src;
    reg [1:0] sec_src;
    reg [1:0] rate_nxt;

    always @*
    begin
        if (spi_mode)
        begin
            eff_bypass = output_control_r[`RCS_BIT_BYPASS];
            eff_mute_n = output_control_r[`RCS_BIT_MUTE];
            eff_clkout = output_control_r[`RCS_BIT_CLKOUT];
        end
        else
        begin
            eff_bypass = bypass_pin;
            eff_mute_n = mute_n_pin;
            eff_clkout = clock_out_select_pin;
        end
        // unsupported rate falls back to bypass
        eff_lock = pll_locked && rate_supported && ~eff_bypass;
        if (spi_mode && ovr_on)
        begin
            case (pri_sel)
                2'b01:   pri_src = `RCS_SRC_BYPASS;
                2'b10:   pri_src = `RCS_SRC_MUTE;
                default: pri_src = data_src(eff_lock);
            endcase
            case (sec_sel)
                2'b00:   sec_src = eff_lock ? `RCS_SRC_CLOCK
                                            : `RCS_SRC_MUTE;
                2'b01:   sec_src = data_src(eff_lock);
                2'b11:   sec_src = `RCS_SRC_BYPASS;
                default: sec_src = `RCS_SRC_MUTE;
            endcase
        end
        else if (!eff_mute_n)
        begin
            pri_src = `RCS_SRC_MUTE;
            sec_src = `RCS_SRC_MUTE;
        end
        else
        begin
            pri_src = data_src(eff_lock);
            if (eff_clkout)
            begin
                sec_src = eff_lock ? `RCS_SRC_CLOCK
                                   : `RCS_SRC_MUTE;
            end
            else
            begin
                sec_src = data_src(eff_lock);
            end
        end
        if (spi_mode && rate_pin_override_r[`RCS_BIT_RATEOV])
        begin
            rate_nxt = rate_restriction_select_r[1:0];
        end
        else
        begin
            rate_nxt = {rate_pin_high, rate_pin_low};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reference detection: count reference edges per window
    reg        ref_s1_r;
    reg        ref_s2_r;
    reg        ref_s3_r;
    reg [9:0]  win_cnt_r;
    reg [7:0]  edge_cnt_r;
    wire       ref_rise = ref_s2_r & ~ref_s3_r;

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ref_s1_r               <= 1'b0;
            ref_s2_r               <= 1'b0;
            ref_s3_r               <= 1'b0;
            win_cnt_r              <= 10'h000;
            edge_cnt_r             <= 8'h00;
            reference_present_flag <= 1'b0;
        end
        else
        begin
            ref_s1_r <= reference_input;
            ref_s2_r <= ref_s1_r;
            ref_s3_r <= ref_s2_r;
            win_cnt_r <= win_cnt_r + 10'h001;
            if (win_cnt_r == 10'h3ff)
            begin
                reference_present_flag <=
                    (edge_cnt_r >= `RCS_REF_MIN_EDGES);
                edge_cnt_r <= 8'h00;
            end
            else if (ref_rise && edge_cnt_r != `RCS_REF_MAX_EDGES)
            begin
                edge_cnt_r <= edge_cnt_r + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register file and outputs
    reg [2:0] rate_stat_nxt;

    always @*
    begin
        if (!eff_lock)
        begin
            rate_stat_nxt = 3'b111;
        end
        else if (reference_present_flag)
        begin
            rate_stat_nxt = {rate_detected[2:1],
                             rate_detected[0] & ~rate_fractional};
        end
        else
        begin
            rate_stat_nxt = rate_detected;
        end
    end

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            manual_output_override_r  <= `RCS_RST_OVERRIDE;
            output_control_r          <= `RCS_RST_OUTCTL;
            rate_restriction_select_r <= `RCS_RST_RATESEL;
            rate_pin_override_r       <= `RCS_RST_RATEOV;
            manual_output_select_r    <= `RCS_RST_OUTSEL;
            reg_rdata                 <= 8'h00;
            reg_rvalid                <= 1'b0;
            primary_serial_out        <= 1'b0;
            secondary_serial_out      <= 1'b0;
            lock_detect               <= 1'b0;
            rate_restrict             <= 2'b00;
            rate_status               <= 3'b111;
            eye_monitor_enable        <= 1'b0;
        end
        else
        begin
            if (reg_wr)
            begin
                case (reg_addr)
                    `RCS_ADDR_OVERRIDE: manual_output_override_r <= reg_wdata;
                    `RCS_ADDR_OUTCTL:   output_control_r <= reg_wdata;
                    `RCS_ADDR_RATESEL:  rate_restriction_select_r <= reg_wdata;
                    `RCS_ADDR_RATEOV:   rate_pin_override_r <= reg_wdata;
                    `RCS_ADDR_OUTSEL:   manual_output_select_r <= reg_wdata;
                    default:            ;
                endcase
            end
            reg_rvalid <= reg_rd;
            if (reg_rd)
            begin
                case (reg_addr)
                    `RCS_ADDR_OVERRIDE: reg_rdata <= manual_output_override_r;
                    `RCS_ADDR_OUTCTL:   reg_rdata <= output_control_r;
                    `RCS_ADDR_RATESEL:  reg_rdata <= rate_restriction_select_r;
                    `RCS_ADDR_RATEOV:   reg_rdata <= rate_pin_override_r;
                    `RCS_ADDR_OUTSEL:   reg_rdata <= manual_output_select_r;
                    `RCS_ADDR_REFSTAT:  reg_rdata <=
                        {4'h0, reference_present_flag, 3'h0};
                    default:            reg_rdata <= 8'h00;
                endcase
            end
            primary_serial_out   <= drive_src(pri_src, reclocked_data,
                                              bypassed_data,
                                              recovered_clock);
            secondary_serial_out <= drive_src(sec_src, reclocked_data,
                                              bypassed_data,
                                              recovered_clock);
            lock_detect          <= eff_lock;
            eye_monitor_enable   <= eff_lock;
            rate_restrict        <= rate_nxt;
            rate_status          <= rate_stat_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bypass sample buffer
    wire [7:0] fifo_data;
    wire       fifo_valid;
    wire       fifo_in_ready;
    wire       fifo_take = fifo_valid && (~bypass_stream_valid ||
                                          bypass_stream_ready);

    rcs_fifo #(
        .WIDTH (`RCS_FIFO_WIDTH),
        .DEPTH (`RCS_FIFO_DEPTH),
        .AW    (4)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_data   (sample_data),
        .in_valid  (sample_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_take)
    );

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            bypass_stream_data  <= 8'h00;
            bypass_stream_valid <= 1'b0;
            sample_ready        <= 1'b0;
        end
        else
        begin
            sample_ready <= fifo_in_ready;
            if (fifo_take)
            begin
                bypass_stream_data  <= fifo_data;
                bypass_stream_valid <= 1'b1;
            end
            else if (bypass_stream_ready)
            begin
                bypass_stream_valid <= 1'b0;
            end
        end
    end
endmodule

//--- verif/rcs_output_select_props.sv
`timescale 1ns/10ps
module rcs_chk (
    input wire       clk,
    input wire       reset,
    input wire       spi_mode,
    input wire       bypass_pin,
    input wire       mute_n_pin,
    input wire       clock_out_select_pin,
    input wire       rate_pin_low,
    input wire       rate_pin_high,
    input wire       pll_locked,
    input wire       rate_supported,
    input wire       reclocked_data,
    input wire       bypassed_data,
    input wire       recovered_clock,
    input wire       reg_rd,
    input wire       reg_rvalid,
    input wire       primary_serial_out,
    input wire       secondary_serial_out,
    input wire       lock_detect,
    input wire [1:0] rate_restrict,
    input wire       eye_monitor_enable
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (reset);
    // pin mode, outputs not muted
    wire pm = !spi_mode && mute_n_pin;
    wire lk = pll_locked && rate_supported && !bypass_pin;
    wire pri = primary_serial_out;
    wire sec = secondary_serial_out;
    ////////////////////////////////////////////////////////////////////////
    a_lock_gated: assert property (
        !spi_mode && bypass_pin |=> !lock_detect)
        else $error("lock shown while bypassed");
    a_mute_zero: assert property (
        !spi_mode && !mute_n_pin |=> !pri && !sec)
        else $error("muted output not low");
    a_bypass_both: assert property (
        pm && bypass_pin && !clock_out_select_pin
        |=> pri == $past(bypassed_data) && sec == $past(bypassed_data))
        else $error("bypass data missing");
    a_clk_sec_mute: assert property (
        pm && clock_out_select_pin && !lk |=> !sec)
        else $error("clock output not muted");
    a_clk_sec_out: assert property (
        pm && clock_out_select_pin && lk |=> sec == $past(recovered_clock))
        else $error("recovered clock missing");
    a_reclock_out: assert property (
        pm && lk |=> pri == $past(reclocked_data))
        else $error("reclocked data missing");
    a_unsup_bypass: assert property (
        pm && !rate_supported |=> pri == $past(bypassed_data))
        else $error("unsupported rate not bypassed");
    a_rate_pins: assert property (
        !spi_mode |=> rate_restrict == $past({rate_pin_high, rate_pin_low}))
        else $error("rate restriction wrong");
    a_eye_lock: assert property (
        eye_monitor_enable == lock_detect)
        else $error("eye monitor on without lock");
    a_eye_bypass: assert property (
        !spi_mode && bypass_pin |=> !eye_monitor_enable)
        else $error("eye monitor on while bypassed");
    a_rd_answer: assert property (
        reg_rvalid == $past(reg_rd))
        else $error("read answer missing");
endmodule
bind rcs_output_select rcs_chk u_chk (.*);

//--- verif/rcs_far_end.sv
`timescale 1ns/10ps
module rcs_far_end (
    input  wire       clk,
    input  wire       ref_on,
    input  wire       stall,
    output reg        reclocked_data,
    output reg        bypassed_data,
    output reg        recovered_clock,
    output reg        pll_locked,
    output reg        rate_supported,
    output reg        rate_fractional,
    output reg  [2:0] rate_detected,
    output reg        reference_input,
    output reg        bypass_stream_ready
);
    initial
    begin
        {reclocked_data, bypassed_data, recovered_clock} = 3'h0;
        {pll_locked, rate_supported, rate_fractional} = 3'h0;
        rate_detected = 3'h0;
        reference_input = 1'b0;
        bypass_stream_ready = 1'b0;
    end
    // reference input is grounded when no reference is fitted
    always #18.52 reference_input = ref_on & ~reference_input;
    always @(posedge clk)
    begin
        {reclocked_data, bypassed_data, recovered_clock} <= 3'($urandom);
        pll_locked <= $urandom % 8 != 0;
        rate_supported <= $urandom % 4 != 0;
        rate_fractional <= 1'($urandom);
        rate_detected <= 3'($urandom);
        bypass_stream_ready <= !stall && 1'($urandom);
    end
endmodule

//--- verif/rcs_output_select_tb.sv
`timescale 1ns/10ps
module rcs_output_select_tb;
    reg        clk, reset, spi_mode, bypass_pin, mute_n_pin;
    reg        clock_out_select_pin, rate_pin_low, rate_pin_high;
    reg        reg_wr, reg_rd, sample_valid, ref_on, stall;
    reg  [7:0] reg_addr, reg_wdata, sample_data;
    wire       reclocked_data, bypassed_data, recovered_clock, pll_locked;
    wire       rate_supported, rate_fractional, reference_input;
    wire       reg_rvalid, primary_serial_out, secondary_serial_out;
    wire       lock_detect, reference_present_flag, eye_monitor_enable;
    wire       bypass_stream_valid, sample_ready, bypass_stream_ready;
    wire [1:0] rate_restrict;
    wire [2:0] rate_detected, rate_status;
    wire [7:0] reg_rdata, bypass_stream_data;
    integer    err_count, n_tests, i, j;
    reg  [7:0] sh [0:255];
    reg  [7:0] q [$];
    reg [47:0] lst;

    rcs_output_select dut (.*);
    rcs_far_end far (.*);

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task check(input [31:0] seen, input [31:0] exp);
    begin
        n_tests = n_tests + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask

    task wr(input [7:0] a, input [7:0] d);
    begin
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        sh[a] = d;
        @(posedge clk);
        reg_wr <= 1'b0;
    end
    endtask

    task rd_chk(input [7:0] a, input [7:0] e);
    begin
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(reg_rdata, e);
    end
    endtask

    // {rate_restrict, lock, primary, secondary} from last edge's inputs
    function [4:0] model(input [10:0] p);
        reg       s, b, m, c, lk;
        reg [1:0] s0, s1, o, rr;
    begin
        s = p[10];
        b = s ? sh[8'h12][2] : p[9];
        m = s ? sh[8'h12][1] : p[8];
        c = s ? sh[8'h12][0] : p[7];
        lk = p[4] & p[3] & ~b;
        s0 = sh[8'h1e][6:5];
        s1 = sh[8'h1e][4:3];
        rr = s && sh[8'h1d][0] ? sh[8'h1c][1:0] : p[6:5];
        if (s && sh[8'h09][5])
            o = {s0 == 2'h2 ? 1'b0 : s0 == 2'h1 || !lk ? p[1] : p[2],
                 s1[1] ? s1[0] & p[1] : s1[0] ? (lk ? p[2] : p[1])
                 : lk & p[0]};
        else if (!m)
            o = 2'h0;
        else
            o = {lk ? p[2] : p[1], c ? lk & p[0] : lk ? p[2] : p[1]};
        model = {rr, lk, o};
    end
    endfunction

    task run(input integer n);
        reg [10:0] p;
        reg [3:0]  r;
        reg [4:0]  e;
        reg [2:0]  s;
        integer    k;
    begin
        for (k = 0; k < n; k = k + 1)
        begin
            @(posedge clk);
            p = {spi_mode, bypass_pin, mute_n_pin, clock_out_select_pin,
                 rate_pin_high, rate_pin_low, pll_locked, rate_supported,
                 reclocked_data, bypassed_data, recovered_clock};
            r = {rate_detected, rate_fractional};
            {bypass_pin, clock_out_select_pin} <= 2'($urandom);
            {rate_pin_high, rate_pin_low} <= 2'($urandom);
            mute_n_pin <= $urandom % 4 != 0;
            @(negedge clk);
            e = model(p);
            // fractional variants only told apart with a reference
            s = {r[3:2], r[1] & ~(ref_on & r[0])};
            check({rate_restrict, lock_detect, primary_serial_out,
                   secondary_serial_out}, e);
            check(rate_status, e[2] ? s : 3'h7);
            check(eye_monitor_enable, e[2]);
        end
    end
    endtask

    task end_of_test;
    begin
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #200000;
        err_count = err_count + 1;
        end_of_test;
    end

    initial
    begin
        i = $urandom(32'hdfe2_dbaa);
        {spi_mode, bypass_pin, clock_out_select_pin, reg_wr, reg_rd} = 5'h00;
        {rate_pin_low, rate_pin_high, sample_valid, ref_on} = 4'h0;
        {reg_addr, reg_wdata, sample_data} = 24'h00_0000;
        {mute_n_pin, stall, reset} = 3'h7;
        err_count = 0;
        n_tests = 0;
        for (i = 0; i < 256; i = i + 1)
            sh[i] = 8'h00;
        sh[8'h12] = 8'h02;
        lst = 48'h0009_121c_1d1e;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        spi_mode <= 1'b1;
        for (i = 0; i < 6; i = i + 1)
            rd_chk(lst[8*i+:8], sh[lst[8*i+:8]]);
        for (i = 0; i < 6; i = i + 1)
            wr(lst[8*i+:8], 8'($urandom));
        sh[8'h00] = 8'h00;
        wr(8'h41, 8'hff);
        for (i = 0; i < 6; i = i + 1)
            rd_chk(lst[8*i+:8], sh[lst[8*i+:8]]);
        rd_chk(8'h41, 8'h00);
        $display("register test done");
        wr(8'h09, 8'h00);
        wr(8'h1d, 8'h00);
        spi_mode <= 1'b0;
        run(300);
        $display("pin mode test done");
        spi_mode <= 1'b1;
        for (i = 0; i < 8; i = i + 1)
        begin
            wr(8'h12, 8'(i));
            run(20);
        end
        wr(8'h09, 8'h20);
        for (i = 0; i < 32; i = i + 1)
        begin
            wr(8'h1e, 8'(i % 16) << 3);
            wr(8'h12, 8'(i / 16 * 4 + $urandom % 4));
            run(10);
        end
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(8'h1c, 8'(i));
            wr(8'h1d, 8'h01);
            run(8);
            wr(8'h1d, 8'h00);
            run(8);
        end
        wr(8'h09, 8'h00);
        wr(8'h12, 8'h02);
        $display("register mode test done");
        for (i = 1; i >= 0; i = i - 1)
        begin
            ref_on = i[0];
            repeat (2100) @(posedge clk);
            @(negedge clk);
            check(reference_present_flag, i);
            rd_chk(8'h41, 8'(i * 8));
            run(40);
        end
        $display("reference test done");
        // one word sits in the output register, sixteen fill the buffer
        for (i = 0; i < 17; i = i + 1)
        begin
            @(posedge clk);
            j = $urandom;
            sample_valid <= 1'b1;
            sample_data <= j[7:0];
            q.push_back(j[7:0]);
        end
        @(posedge clk);
        sample_valid <= 1'b0;
        repeat (3) @(negedge clk);
        check(sample_ready, 0);
        stall <= 1'b0;
        for (j = 0; j < 300 && q.size() > 0; j = j + 1)
        begin
            @(posedge clk);
            if (bypass_stream_valid && bypass_stream_ready)
                check(bypass_stream_data, q.pop_front());
        end
        check(q.size(), 0);
        @(negedge clk);
        check(sample_ready, 1);
        $display("stream test done");
        end_of_test;
    end
endmodule
